// ==== nfcpt_pkg.sv ====
package nfcpt_pkg;
  // ==========================================
  // register indices and byte addresses
  localparam logic [7:0] IDX_SQ = 8'h0f;
  localparam logic [7:0] IDX_TC = 8'h12;
  localparam logic [7:0] IDX_GPT_HI = 8'h13;
  localparam logic [7:0] IDX_GPT_LO = 8'h14;
  localparam logic [7:0] IDX_PPW = 8'h15;
  localparam logic [7:0] IDX_CMD = 8'h1e;
  localparam logic [7:0] IDX_STAT = 8'h1f;
  localparam logic [7:0] ADDR_SQ = {IDX_SQ[5:0], 2'b00};
  localparam logic [7:0] ADDR_TC = {IDX_TC[5:0], 2'b00};
  localparam logic [7:0] ADDR_GPT_HI = {IDX_GPT_HI[5:0], 2'b00};
  localparam logic [7:0] ADDR_GPT_LO = {IDX_GPT_LO[5:0], 2'b00};
  localparam logic [7:0] ADDR_PPW = {IDX_PPW[5:0], 2'b00};
  localparam logic [7:0] ADDR_CMD = {IDX_CMD[5:0], 2'b00};
  localparam logic [7:0] ADDR_STAT = {IDX_STAT[5:0], 2'b00};
  // ==========================================
  // timer control fields and reset values
  localparam int TC_TRIG_LSB = 5;
  localparam int TC_MRT_STEP = 3;
  localparam int TC_NRT_PEER = 2;
  localparam int TC_NRT_COMPL = 1;
  localparam int TC_NRT_STEP = 0;
  localparam int CMD_START_GPT = 0;
  localparam logic [2:0] TRIG_RX_END = 3'h1;
  localparam logic [2:0] TRIG_RX_START = 3'h2;
  localparam logic [2:0] TRIG_TX_END = 3'h3;
  localparam logic [7:0] RST_SQ = 8'h00;
  localparam logic [7:0] RST_TC = 8'h00;
  localparam logic [7:0] RST_GPT = 8'h00;
  localparam logic [7:0] RST_PPW = 8'h80;
  // ==========================================
  // step sizes in carrier periods, squelch timing
  localparam logic [9:0] GPT_STEP = 10'h008;
  localparam logic [9:0] PPW_STEP = 10'h040;
  localparam logic [9:0] MRT_STEP_SHORT = 10'h040;
  localparam logic [9:0] MRT_STEP_LONG = 10'h200;
  localparam logic [7:0] SQ_MIN = 8'h05;
  localparam int CLK_PERIOD_NS = 10;
  localparam int SQ_DELAY_NS = 20000;
  localparam int SQ_DELAY_CYC = (SQ_DELAY_NS + CLK_PERIOD_NS - 1)
    / CLK_PERIOD_NS;
endpackage : nfcpt_pkg

// ==== nfcpt_tmr_if.sv ====
// ==========================================
// control bundle between the block and one down timer
interface nfcpt_tmr_if;
  logic start;
  logic stop;
  logic [15:0] load;
  logic [9:0] step_len;
  logic running;
  logic expired;
  modport ctrl (output start, stop, load, step_len, input running, expired);
  modport tmr (input start, stop, load, step_len, output running, expired);
endinterface : nfcpt_tmr_if

// ==== nfcpt_down_timer.sv ====
// ==========================================
// prescaled down counter clocked by carrier ticks
module nfcpt_down_timer (
  input wire logic clk_sys_in,
  input wire logic rstn_in,
  input wire logic fc_tick_in,
  nfcpt_tmr_if.tmr t
);
  logic [15:0] cnt, next_cnt;
  logic [9:0] pre, next_pre;
  logic run, next_run;
  logic exp, next_exp;

  // start wins over stop and over a running count
  always_comb begin
    next_cnt = cnt;
    next_pre = pre;
    next_run = run;
    next_exp = 1'b0;
    if (t.start) begin
      next_cnt = t.load;
      next_pre = 10'h000;
      next_run = (t.load != 16'h0000);
    end else if (t.stop) begin
      next_run = 1'b0;
    end else if (run && fc_tick_in) begin
      if (pre == t.step_len - 10'h001) begin
        next_pre = 10'h000;
        next_cnt = cnt - 16'h0001;
        if (cnt == 16'h0001) begin
          next_run = 1'b0;
          next_exp = 1'b1;
        end
      end else begin
        next_pre = pre + 10'h001;
      end
    end
  end

  always_ff @(posedge clk_sys_in) begin
    if (!rstn_in) begin
      cnt <= 16'h0000;
      pre <= 10'h000;
      run <= 1'b0;
      exp <= 1'b0;
    end else begin
      cnt <= next_cnt;
      pre <= next_pre;
      run <= next_run;
      exp <= next_exp;
    end
  end

  assign t.running = run;
  assign t.expired = exp;

  // ==========================================
  // checks
  default clocking cb @(posedge clk_sys_in); endclocking
  default disable iff (!rstn_in);
  a_timer_reload: assert property (
    t.start && t.load != 16'h0000 |=> run && cnt == $past(t.load, 1))
    else $error("timer did not reload on start");
  a_expire_cause: assert property (
    exp |-> $past(run) && $past(cnt) == 16'h0001 && $past(fc_tick_in))
    else $error("expiry without final step");
endmodule : nfcpt_down_timer

// ==== nfcpt_start_sel.sv ====
// ==========================================
// start event decode for the general and no-response timers
module nfcpt_start_sel (
  input wire logic [2:0] code_in,
  input wire logic cmd_start_in,
  input wire logic rx_end_in,
  input wire logic rx_start_in,
  input wire logic tx_end_in,
  input wire logic act_p2p_in,
  input wire logic nrt_on_peer_in,
  input wire logic peer_on_in,
  output logic gpt_start_out,
  output logic p2p_arm_out,
  output logic nrt_start_out
);
  import nfcpt_pkg::*;
  // direct command always starts, the code adds one more source
  assign gpt_start_out = cmd_start_in
    | (code_in == TRIG_RX_END && rx_end_in)
    | (code_in == TRIG_RX_START && rx_start_in)
    | (code_in == TRIG_TX_END && tx_end_in);
  assign p2p_arm_out = act_p2p_in && code_in == TRIG_TX_END;
  // start condition bit picks tx end or peer field on
  assign nrt_start_out = p2p_arm_out
    && (nrt_on_peer_in ? peer_on_in : tx_end_in);
endmodule : nfcpt_start_sel

// ==== nfcpt_timer_cfg.sv ====
// Behaviour
// - direct command always starts general timer
// - trigger code adds one extra start source
// - active p2p, tx-end code: expiry drops field
// - active p2p, tx-end code arms no-response start
// - control bit 3 picks mask-receive step
// - no-response start at tx end or peer-on
// - control bit 1 selects compliance mode
// - control bit 0 picks no-response step
// - 16-bit general timeout in 8-period steps
// - 8-bit peer-field wait in 64-period steps
// - squelch on about 20 us after tx
// - short squelch ends on own timer, gain held
// - otherwise squelch lasts until mask-receive expiry
// - squelch timer steps like mask-receive timer
// - general timer expiry raises event
// - peer-field wait expiry raises event
module nfcpt_timer_cfg (
  input wire logic clk_sys_in,
  input wire logic rstn_in,
  input wire logic psel_in,
  input wire logic penable_in,
  input wire logic pwrite_in,
  input wire logic [7:0] paddr_in,
  input wire logic [31:0] pwdata_in,
  input wire logic fc_tick_in,
  input wire logic active_peer_to_peer_mode_in,
  input wire logic rx_start_in,
  input wire logic rx_end_in,
  input wire logic tx_end_in,
  input wire logic peer_field_on_in,
  input wire logic [7:0] mrt_value_in,
  input wire logic mrt_expire_in,
  output logic [31:0] prdata_out,
  output logic pready_out,
  output logic pslverr_out,
  output logic field_off_out,
  output logic nrt_start_out,
  output logic nrt_step_long_out,
  output logic nrt_compliance_out,
  output logic mrt_step_long_out,
  output logic gpt_expire_out,
  output logic peer_field_wait_expire_out,
  output logic squelch_on_out,
  output logic gain_hold_out
);
  import nfcpt_pkg::*;

  typedef enum logic [1:0] {
    SQ_IDLE, SQ_DELAY, SQ_ACTIVE
  } nfcpt_sq_type;

  logic [7:0] squelch_time, next_squelch_time;
  logic [7:0] timer_control, next_timer_control;
  logic [7:0] general_timeout_high, next_general_timeout_high;
  logic [7:0] general_timeout_low, next_general_timeout_low;
  logic [7:0] peer_field_wait_time, next_peer_field_wait_time;
  logic [31:0] next_prdata;
  logic next_pready, next_pslverr;
  logic bus_wr, bus_rd, cmd_start;
  logic gpt_start, p2p_arm, nrt_start;
  logic [7:0] status;

  nfcpt_tmr_if gpt_if ();
  nfcpt_tmr_if ppw_if ();
  nfcpt_tmr_if squelch_if ();

  // ==========================================
  // apb slave
  function automatic logic addr_known(input logic [7:0] a);
    addr_known = a == ADDR_SQ || a == ADDR_TC || a == ADDR_GPT_HI
      || a == ADDR_GPT_LO || a == ADDR_PPW || a == ADDR_CMD
      || a == ADDR_STAT;
  endfunction : addr_known

  // one wait state keeps every bus output a flip-flop
  assign bus_wr = psel_in && penable_in && pready_out && pwrite_in;
  assign bus_rd = psel_in && penable_in && !pready_out && !pwrite_in;
  assign cmd_start = bus_wr && paddr_in == ADDR_CMD
    && pwdata_in[CMD_START_GPT];

  // register writes
  always_comb begin
    next_squelch_time = squelch_time;
    next_timer_control = timer_control;
    next_general_timeout_high = general_timeout_high;
    next_general_timeout_low = general_timeout_low;
    next_peer_field_wait_time = peer_field_wait_time;
    if (bus_wr) begin
      case (paddr_in)
        ADDR_SQ: next_squelch_time = pwdata_in[7:0];
        ADDR_TC: next_timer_control = {pwdata_in[7:5], 1'b0, pwdata_in[3:0]};
        ADDR_GPT_HI: next_general_timeout_high = pwdata_in[7:0];
        ADDR_GPT_LO: next_general_timeout_low = pwdata_in[7:0];
        ADDR_PPW: next_peer_field_wait_time = pwdata_in[7:0];
        default: ;
      endcase
    end
  end

  // read data, ready and error for the access phase
  always_comb begin
    next_pready = psel_in && penable_in && !pready_out;
    next_pslverr = next_pready && !addr_known(paddr_in);
    next_prdata = 32'h0000_0000;
    if (bus_rd) begin
      case (paddr_in)
        ADDR_SQ: next_prdata = {24'h00_0000, squelch_time};
        ADDR_TC: next_prdata = {24'h00_0000, timer_control};
        ADDR_GPT_HI: next_prdata = {24'h00_0000, general_timeout_high};
        ADDR_GPT_LO: next_prdata = {24'h00_0000, general_timeout_low};
        ADDR_PPW: next_prdata = {24'h00_0000, peer_field_wait_time};
        ADDR_STAT: next_prdata = {24'h00_0000, status};
        default: next_prdata = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge clk_sys_in) begin
    if (!rstn_in) begin
      squelch_time <= RST_SQ;
      timer_control <= RST_TC;
      general_timeout_high <= RST_GPT;
      general_timeout_low <= RST_GPT;
      peer_field_wait_time <= RST_PPW;
      prdata_out <= 32'h0000_0000;
      pready_out <= 1'b0;
      pslverr_out <= 1'b0;
    end else begin
      squelch_time <= next_squelch_time;
      timer_control <= next_timer_control;
      general_timeout_high <= next_general_timeout_high;
      general_timeout_low <= next_general_timeout_low;
      peer_field_wait_time <= next_peer_field_wait_time;
      prdata_out <= next_prdata;
      pready_out <= next_pready;
      pslverr_out <= next_pslverr;
    end
  end

  // ==========================================
  // start decode and timers
  nfcpt_start_sel u_sel (
    .code_in(timer_control[TC_TRIG_LSB +: 3]),
    .cmd_start_in(cmd_start),
    .rx_end_in(rx_end_in),
    .rx_start_in(rx_start_in),
    .tx_end_in(tx_end_in),
    .act_p2p_in(active_peer_to_peer_mode_in),
    .nrt_on_peer_in(timer_control[TC_NRT_PEER]),
    .peer_on_in(peer_field_on_in),
    .gpt_start_out(gpt_start),
    .p2p_arm_out(p2p_arm),
    .nrt_start_out(nrt_start)
  );

  // general timer, 16-bit value in 8-period steps
  assign gpt_if.start = gpt_start;
  assign gpt_if.stop = 1'b0;
  assign gpt_if.load = {general_timeout_high, general_timeout_low};
  assign gpt_if.step_len = GPT_STEP;

  // peer-field wait runs from tx end in active p2p mode until the peer field shows up
  assign ppw_if.start = active_peer_to_peer_mode_in && tx_end_in;
  assign ppw_if.stop = peer_field_on_in;
  assign ppw_if.load = {8'h00, peer_field_wait_time};
  assign ppw_if.step_len = PPW_STEP;

  // squelch timer shares the mask-receive step choice
  assign squelch_if.start = tx_end_in;
  assign squelch_if.stop = 1'b0;
  assign squelch_if.load = {8'h00, squelch_time};
  assign squelch_if.step_len = timer_control[TC_MRT_STEP] ? MRT_STEP_LONG
    : MRT_STEP_SHORT;

  nfcpt_down_timer u_gpt (
    .clk_sys_in(clk_sys_in),
    .rstn_in(rstn_in),
    .fc_tick_in(fc_tick_in),
    .t(gpt_if)
  );

  nfcpt_down_timer u_ppw (
    .clk_sys_in(clk_sys_in),
    .rstn_in(rstn_in),
    .fc_tick_in(fc_tick_in),
    .t(ppw_if)
  );

  nfcpt_down_timer u_squelch (
    .clk_sys_in(clk_sys_in),
    .rstn_in(rstn_in),
    .fc_tick_in(fc_tick_in),
    .t(squelch_if)
  );

  // ==========================================
  // squelch sequence
  nfcpt_sq_type sq_state, next_sq_state;
  logic [15:0] sq_cnt, next_sq_cnt;
  logic sq_own, next_sq_own;
  logic sq_done, next_sq_done;
  logic next_gain_hold, sq_own_now;

  // own end only for a value above the floor and below the mask time
  assign sq_own_now = squelch_time > SQ_MIN
    && squelch_time < mrt_value_in;

  // squelch timer may expire before the 20 us delay ends, so remember it
  always_comb begin
    next_sq_state = sq_state;
    next_sq_cnt = sq_cnt;
    next_sq_own = sq_own;
    next_sq_done = sq_done || squelch_if.expired;
    next_gain_hold = gain_hold_out;
    case (sq_state)
      SQ_IDLE: ;
      SQ_DELAY: begin
        next_sq_cnt = sq_cnt + 16'h0001;
        if (sq_cnt == 16'(SQ_DELAY_CYC - 1)) begin
          next_sq_state = SQ_ACTIVE;
        end
      end
      SQ_ACTIVE: begin
        if (sq_own && next_sq_done) begin
          next_sq_state = SQ_IDLE;
          next_gain_hold = 1'b1;
        end else if (!sq_own && mrt_expire_in) begin
          next_sq_state = SQ_IDLE;
        end
      end
      default: next_sq_state = SQ_IDLE;
    endcase
    if (tx_end_in) begin
      next_sq_state = SQ_DELAY;
      next_sq_cnt = 16'h0000;
      next_sq_own = sq_own_now;
      next_sq_done = 1'b0;
      next_gain_hold = 1'b0;
    end
  end

  always_ff @(posedge clk_sys_in) begin
    if (!rstn_in) begin
      sq_state <= SQ_IDLE;
      sq_cnt <= 16'h0000;
      sq_own <= 1'b0;
      sq_done <= 1'b0;
      gain_hold_out <= 1'b0;
    end else begin
      sq_state <= next_sq_state;
      sq_cnt <= next_sq_cnt;
      sq_own <= next_sq_own;
      sq_done <= next_sq_done;
      gain_hold_out <= next_gain_hold;
    end
  end

  // ==========================================
  // registered outputs
  assign status = {3'h0, gain_hold_out, squelch_on_out, squelch_if.running,
    ppw_if.running, gpt_if.running};

  always_ff @(posedge clk_sys_in) begin
    if (!rstn_in) begin
      field_off_out <= 1'b0;
      nrt_start_out <= 1'b0;
      nrt_step_long_out <= 1'b0;
      nrt_compliance_out <= 1'b0;
      mrt_step_long_out <= 1'b0;
      gpt_expire_out <= 1'b0;
      peer_field_wait_expire_out <= 1'b0;
      squelch_on_out <= 1'b0;
    end else begin
      field_off_out <= p2p_arm && gpt_if.expired;
      nrt_start_out <= nrt_start;
      nrt_step_long_out <= timer_control[TC_NRT_STEP];
      nrt_compliance_out <= timer_control[TC_NRT_COMPL];
      mrt_step_long_out <= timer_control[TC_MRT_STEP];
      gpt_expire_out <= gpt_if.expired;
      peer_field_wait_expire_out <= ppw_if.expired;
      squelch_on_out <= next_sq_state == SQ_ACTIVE;
    end
  end

  // ==========================================
  // checks
  default clocking cb @(posedge clk_sys_in); endclocking
  default disable iff (!rstn_in);

  a_cmd_starts_gpt: assert property (
    cmd_start && gpt_if.load != 16'h0000 |=> gpt_if.running)
    else $error("direct command did not start general timer");
  a_trig_rx_end: assert property (
    timer_control[7:5] == TRIG_RX_END && rx_end_in |-> gpt_start)
    else $error("end of rx trigger missed");
  a_trig_reserved: assert property (
    timer_control[7] && !cmd_start |-> !gpt_start)
    else $error("reserved trigger code started timer");
  a_field_off: assert property (
    gpt_if.expired && p2p_arm |=> field_off_out)
    else $error("field not dropped on expiry");
  a_nrt_start_sel: assert property (
    p2p_arm && !timer_control[TC_NRT_PEER] && tx_end_in
    |=> nrt_start_out)
    else $error("no-response start at tx end missed");
  a_nrt_no_arm: assert property (
    !p2p_arm |=> !nrt_start_out)
    else $error("no-response start without arming");
  a_mrt_step: assert property (
    ##1 mrt_step_long_out == $past(timer_control[TC_MRT_STEP])
    && (squelch_if.step_len == MRT_STEP_LONG) == timer_control[TC_MRT_STEP])
    else $error("mask-receive step mismatch");
  a_nrt_mode_bits: assert property (
    $changed(timer_control) |=> nrt_compliance_out
    == $past(timer_control[TC_NRT_COMPL])
    && nrt_step_long_out == $past(timer_control[TC_NRT_STEP]))
    else $error("no-response mode bits not forwarded");
  a_gpt_step: assert property (
    gpt_if.step_len == GPT_STEP && ppw_if.step_len == PPW_STEP)
    else $error("timer step size wrong");
  a_sq_delay: assert property (
    tx_end_in |=> !squelch_on_out [*8])
    else $error("squelch enabled too early");
  a_sq_own_end: assert property (
    sq_state == SQ_ACTIVE && sq_own && next_sq_done && !tx_end_in
    |=> !squelch_on_out && gain_hold_out)
    else $error("short squelch did not end with gain held");
  a_sq_mrt_end: assert property (
    sq_state == SQ_ACTIVE && !sq_own && !mrt_expire_in && !tx_end_in
    |=> squelch_on_out)
    else $error("squelch ended before mask-receive expiry");
  a_expire_events: assert property (
    (gpt_if.expired |=> gpt_expire_out)
    and (ppw_if.expired |=> peer_field_wait_expire_out))
    else $error("expiry event lost");

  c_gpt_expire: cover property (gpt_expire_out);
  c_field_off: cover property (field_off_out);
  c_gain_hold: cover property ($rose(gain_hold_out));
  c_ppw_expire: cover property (peer_field_wait_expire_out);
endmodule : nfcpt_timer_cfg

// ==== test_nfc_protocol_timer_config.sv ====
module test_nfc_protocol_timer_config;
  timeunit 1ns;
  timeprecision 1ps;
  import nfcpt_pkg::*;
  // ==========================================
  // bench signals
  localparam int FC_DIV = 7;
  localparam int B_GPT = 0;
  localparam int B_FOFF = 1;
  localparam int B_NRT = 2;
  localparam int B_PPW = 3;
  localparam int B_SQ = 4;
  logic clk_sys_in, rstn_in, psel, penable, pwrite, fc_tick, p2p_mode;
  logic [7:0] paddr, mrt_value;
  logic [31:0] pwdata, prdata, rd;
  logic [4:0] ev; // mrt expire, peer on, tx end, rx start, rx end
  logic pready, pslverr, err, hit;
  logic field_off, nrt_start, nrt_step_long, nrt_compl, mrt_step_long;
  logic gpt_expire, ppw_expire, squelch_on, gain_hold;
  logic [4:0] obs;
  int fail_count = 0;
  int check_count = 0;
  int tick_cnt = 0;
  int fc_cnt = 0;
  int n, t0;
  logic [7:0] addrs [5];
  logic [7:0] rsts [5];
  assign obs = {squelch_on, ppw_expire, nrt_start, field_off, gpt_expire};
  nfcpt_timer_cfg uut (
    .clk_sys_in(clk_sys_in), .rstn_in(rstn_in), .psel_in(psel),
    .penable_in(penable), .pwrite_in(pwrite), .paddr_in(paddr),
    .pwdata_in(pwdata), .fc_tick_in(fc_tick),
    .active_peer_to_peer_mode_in(p2p_mode), .rx_start_in(ev[1]),
    .rx_end_in(ev[0]), .tx_end_in(ev[2]), .peer_field_on_in(ev[3]),
    .mrt_value_in(mrt_value), .mrt_expire_in(ev[4]), .prdata_out(prdata),
    .pready_out(pready), .pslverr_out(pslverr), .field_off_out(field_off),
    .nrt_start_out(nrt_start), .nrt_step_long_out(nrt_step_long),
    .nrt_compliance_out(nrt_compl), .mrt_step_long_out(mrt_step_long),
    .gpt_expire_out(gpt_expire), .peer_field_wait_expire_out(ppw_expire),
    .squelch_on_out(squelch_on), .gain_hold_out(gain_hold));
  // ==========================================
  // clock and carrier tick, one tick per seven cycles near real fc
  initial begin
    clk_sys_in = 1'b0;
    forever #5 clk_sys_in = ~clk_sys_in;
  end
  always @(posedge clk_sys_in) begin
    fc_tick <= (fc_cnt == FC_DIV - 1);
    fc_cnt <= (fc_cnt == FC_DIV - 1) ? 0 : fc_cnt + 1;
    if (fc_cnt == FC_DIV - 1) tick_cnt <= tick_cnt + 1;
  end
  // ==========================================
  // compare and access tasks
  task automatic chk(input string what, input logic [31:0] exp,
                     input logic [31:0] got);
    check_count++;
    if (got !== exp) begin
      fail_count++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  task automatic chk_bit(input string what, input logic exp,
                         input logic got);
    check_count++;
    if (got !== exp) begin
      fail_count++;
      $display("mismatch %s expected %b seen %b", what, exp, got);
    end
  endtask : chk_bit
  // request held until pready is seen at a rising edge
  task automatic apb(input logic wr, input logic [7:0] a,
                     input logic [31:0] wd);
    int k;
    @(posedge clk_sys_in);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge clk_sys_in);
    penable <= 1'b1;
    k = 0;
    do begin
      @(posedge clk_sys_in);
      k++;
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    chk("ready wait", 32'h0000_0002, 32'(k));
  endtask : apb
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask : wr
  task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0000_0000);
    chk("read data", exp, rd);
  endtask : rd_chk
  task automatic pulse(input logic [4:0] m);
    @(posedge clk_sys_in);
    ev <= m;
    @(posedge clk_sys_in);
    ev <= 5'h00;
  endtask : pulse
  // bounded wait for one observed output to reach a level
  task automatic wait_for(input int b, input logic v, input int max);
    n = 0;
    hit = 1'b0;
    while (n < max && !hit) begin
      @(posedge clk_sys_in);
      n++;
      hit = (obs[b] === v);
    end
  endtask : wait_for
  // two starts by command: the second one reloads the count
  task automatic gpt_run(input logic [7:0] hi, input logic [7:0] lo);
    int exp;
    exp = {hi, lo} * 8;
    wr(ADDR_GPT_HI, {24'h00_0000, hi});
    wr(ADDR_GPT_LO, {24'h00_0000, lo});
    wr(ADDR_CMD, 32'h0000_0001);
    repeat (20) @(posedge clk_sys_in);
    wr(ADDR_CMD, 32'h0000_0001);
    t0 = tick_cnt;
    rd_chk(ADDR_STAT, 32'h0000_0001);
    wait_for(B_GPT, 1'b1, 20000);
    chk_bit("gpt expiry", 1'b1, hit);
    chk_bit("gpt ticks", 1'b1, tick_cnt - t0 inside {[exp:exp + 2]});
  endtask : gpt_run
  // exp_t zero means squelch must wait for mask-receive expiry
  task automatic sq_run(input logic [7:0] sq_val, input logic [7:0] ctl,
                        input int exp_t);
    wr(ADDR_SQ, {24'h00_0000, sq_val});
    wr(ADDR_TC, {24'h00_0000, ctl});
    pulse(5'h04);
    t0 = tick_cnt;
    repeat (1985) @(posedge clk_sys_in);
    chk_bit("squelch early", 1'b0, squelch_on);
    wait_for(B_SQ, 1'b1, 30);
    chk_bit("squelch on", 1'b1, hit);
    if (exp_t > 0) begin
      wait_for(B_SQ, 1'b0, 30000);
      chk_bit("squelch off", 1'b1, hit);
      chk_bit("sq ticks", 1'b1, tick_cnt - t0 inside {[exp_t:exp_t + 2]});
      @(posedge clk_sys_in);
      chk_bit("gain hold", 1'b1, gain_hold);
    end else begin
      repeat (3000) @(posedge clk_sys_in);
      chk_bit("squelch held", 1'b1, squelch_on);
      chk_bit("no gain hold", 1'b0, gain_hold);
      pulse(5'h10);
      wait_for(B_SQ, 1'b0, 4);
      chk_bit("squelch at mrt", 1'b1, hit);
    end
  endtask : sq_run
  task automatic end_of_test;
    $display("checks %0d mismatches %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : end_of_test
  // ==========================================
  // watchdog, well beyond the expected run of about 55k cycles
  initial begin
    #900_000;
    fail_count++;
    end_of_test();
  end
  // ==========================================
  // main sequence
  initial begin
    rstn_in = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0000_0000;
    p2p_mode = 1'b0;
    ev = 5'h00;
    mrt_value = 8'h14;
    addrs = '{ADDR_SQ, ADDR_TC, ADDR_GPT_HI, ADDR_GPT_LO, ADDR_PPW};
    rsts = '{RST_SQ, RST_TC, RST_GPT, RST_GPT, RST_PPW};
    repeat (16) @(posedge clk_sys_in);
    rstn_in <= 1'b1;
    // reset values, then all ones with the spare control bit reading 0
    for (int i = 0; i < 5; i++) begin
      rd_chk(addrs[i], {24'h00_0000, rsts[i]});
      wr(addrs[i], 32'hffff_ffff);
      rd_chk(addrs[i], (i == 1) ? 32'h0000_00ef : 32'h0000_00ff);
    end
    apb(1'b1, 8'h00, 32'h0000_00ff);
    chk_bit("unmapped write err", 1'b1, err);
    apb(1'b0, 8'h00, 32'h0000_0000);
    chk_bit("unmapped read err", 1'b1, err);
    chk("unmapped read", 32'h0000_0000, rd);
    rd_chk(ADDR_CMD, 32'h0000_0000);
    // step and mode levels, bits set apart so swaps show
    wr(ADDR_TC, 32'h0000_000a);
    repeat (2) @(posedge clk_sys_in);
    chk_bit("mrt step", 1'b1, mrt_step_long);
    chk_bit("compliance", 1'b1, nrt_compl);
    chk_bit("nrt step", 1'b0, nrt_step_long);
    wr(ADDR_TC, 32'h0000_0001);
    repeat (2) @(posedge clk_sys_in);
    chk_bit("mrt step", 1'b0, mrt_step_long);
    chk_bit("compliance", 1'b0, nrt_compl);
    chk_bit("nrt step", 1'b1, nrt_step_long);
    wr(ADDR_TC, 32'h0000_0000);
    gpt_run(8'h00, 8'h02);
    gpt_run(8'h01, 8'h00);
    // every trigger code against every event source
    wr(ADDR_GPT_HI, 32'h0000_0000);
    wr(ADDR_GPT_LO, 32'h0000_0001);
    for (int c = 0; c < 8; c++) begin
      for (int e = 0; e < 3; e++) begin
        wr(ADDR_TC, 32'(c) << TC_TRIG_LSB);
        pulse(5'h01 << e);
        wait_for(B_GPT, 1'b1, 120);
        chk_bit("trigger start", (c == e + 1), hit);
      end
    end
    // active peer mode: field off and no-response start choices
    p2p_mode <= 1'b1;
    wr(ADDR_TC, 32'h0000_0060);
    pulse(5'h04);
    wait_for(B_NRT, 1'b1, 3);
    chk_bit("nrt at tx end", 1'b1, hit);
    // field off and expiry pulse in the same cycle
    wait_for(B_FOFF, 1'b1, 120);
    chk_bit("field off", 1'b1, hit);
    chk_bit("gpt at tx end", 1'b1, gpt_expire);
    wr(ADDR_TC, 32'h0000_0064);
    pulse(5'h04);
    wait_for(B_NRT, 1'b1, 5);
    chk_bit("nrt waits peer", 1'b0, hit);
    pulse(5'h08);
    wait_for(B_NRT, 1'b1, 3);
    chk_bit("nrt at peer on", 1'b1, hit);
    wr(ADDR_TC, 32'h0000_0000);
    pulse(5'h04);
    wait_for(B_NRT, 1'b1, 5);
    chk_bit("nrt not armed", 1'b0, hit);
    // peer-field wait runs out after value times 64 ticks
    wr(ADDR_PPW, 32'h0000_0002);
    pulse(5'h04);
    t0 = tick_cnt;
    wait_for(B_PPW, 1'b1, 2000);
    chk_bit("peer wait expiry", 1'b1, hit);
    chk_bit("peer wait ticks", 1'b1, tick_cnt - t0 inside {[128:130]});
    p2p_mode <= 1'b0;
    // squelch: own timer, small value, value equal to mrt, long step
    sq_run(8'h06, 8'h00, 384);
    sq_run(8'h05, 8'h00, 0);
    sq_run(8'h14, 8'h00, 0);
    sq_run(8'h06, 8'h08, 3072);
    end_of_test();
  end
endmodule : test_nfc_protocol_timer_config
